// ### inc/fbssm_pkg.sv
// Purpose: Constants and types for the fieldbus slave state machine
// Assumes: 16-bit register port, 100 MHz clk_in
// Notes:   State codes match the control and status register encoding
package fbssm_pkg;
  // ==========================================================
  // Register offsets and fields
  localparam logic [15:0] CTRL_ADDR   = 16'h0120;
  localparam logic [15:0] STAT_ADDR   = 16'h0130;
  localparam logic [15:0] CODE_ADDR   = 16'h0134;
  localparam int          ACK_BIT     = 4;
  localparam int          FLAG_BIT    = 4;
  localparam logic [4:0]  CTRL_MASK   = 5'h1f;
  // ==========================================================
  // State encoding
  localparam logic [3:0]  ST_INIT     = 4'h1;
  localparam logic [3:0]  ST_PREOP    = 4'h2;
  localparam logic [3:0]  ST_BOOT     = 4'h3;
  localparam logic [3:0]  ST_SAFEOP   = 4'h4;
  localparam logic [3:0]  ST_OP       = 4'h8;
  // ==========================================================
  // Error codes
  localparam logic [15:0] CODE_NONE   = 16'h0000;
  localparam logic [15:0] CODE_UNSPEC = 16'h0001;
  localparam logic [15:0] CODE_BADCHG = 16'h0011;
  localparam logic [15:0] CODE_UNKNWN = 16'h0012;
  localparam logic [15:0] CODE_MBXBT  = 16'h0015;
  localparam logic [15:0] CODE_MBXPO  = 16'h0016;
  localparam logic [15:0] CODE_SMCFG  = 16'h0017;
  localparam logic [15:0] CODE_WDOG   = 16'h001b;
  localparam logic [15:0] CODE_OUTCFG = 16'h001d;
  localparam logic [15:0] CODE_INCFG  = 16'h001e;
  // ==========================================================
  // Reset values
  localparam logic [4:0]  CTRL_RST    = 5'h01;
  localparam logic [15:0] CODE_RST    = 16'h0000;
  localparam logic [15:0] RDATA_RST   = 16'h0000;
  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    FBSSM_INIT   = 5'b00001,
    FBSSM_PREOP  = 5'b00010,
    FBSSM_BOOT   = 5'b00100,
    FBSSM_SAFEOP = 5'b01000,
    FBSSM_OP     = 5'b10000
  } fbssm_state_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fbssm_bus_s;
  typedef struct packed {
    logic unspec_err;
    logic mbx_boot_bad;
    logic mbx_preop_bad;
    logic sm_cfg_bad;
    logic sm_wdog_exp;
    logic out_cfg_bad;
    logic in_cfg_bad;
  } fbssm_fault_s;
endpackage : fbssm_pkg

// ### src/fbssm_top.sv
// Purpose: Application state machine of a fieldbus slave with its three registers
// Assumes: Register port synchronous to clk_in, one access per cycle
// Notes:   Fault inputs are levels sampled every cycle
`timescale 1ns/1ps
`default_nettype none
module fbssm_top (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  // Register port
  input  wire fbssm_pkg::fbssm_bus_s   bus_in,
  output logic [15:0]              rd_data_out,
  // Fault conditions from the rest of the slave
  input  wire fbssm_pkg::fbssm_fault_s fault_in,
  // State view
  output logic [3:0]               state_out,
  output logic                     flag_out,
  output logic [15:0]              code_out
);
  // ==========================================================
  // State and registers
  fbssm_pkg::fbssm_state_e state_reg, state_next;
  logic [4:0]              ctrl_reg;
  logic                    flag_reg;
  logic [15:0]             code_reg, code_next;
  logic [15:0]             rd_data_reg;
  logic                    err_set;
  logic                    ctrl_wr;
  logic [3:0]              cur, req;

  function automatic logic [3:0] enc(input fbssm_pkg::fbssm_state_e s);
    case (s)
      fbssm_pkg::FBSSM_INIT:   enc = fbssm_pkg::ST_INIT;
      fbssm_pkg::FBSSM_PREOP:  enc = fbssm_pkg::ST_PREOP;
      fbssm_pkg::FBSSM_BOOT:   enc = fbssm_pkg::ST_BOOT;
      fbssm_pkg::FBSSM_SAFEOP: enc = fbssm_pkg::ST_SAFEOP;
      fbssm_pkg::FBSSM_OP:     enc = fbssm_pkg::ST_OP;
      default:                 enc = fbssm_pkg::ST_INIT;
    endcase
  endfunction : enc

  function automatic fbssm_pkg::fbssm_state_e dec(input logic [3:0] c);
    case (c)
      fbssm_pkg::ST_PREOP:  dec = fbssm_pkg::FBSSM_PREOP;
      fbssm_pkg::ST_BOOT:   dec = fbssm_pkg::FBSSM_BOOT;
      fbssm_pkg::ST_SAFEOP: dec = fbssm_pkg::FBSSM_SAFEOP;
      fbssm_pkg::ST_OP:     dec = fbssm_pkg::FBSSM_OP;
      default:              dec = fbssm_pkg::FBSSM_INIT;
    endcase
  endfunction : dec

  assign ctrl_wr = bus_in.wr && (bus_in.addr == fbssm_pkg::CTRL_ADDR);
  assign req     = bus_in.wdata[3:0];
  assign cur     = enc(state_reg);

  // ==========================================================
  // Transition decision
  logic known, bad_pair, in_run;
  always_comb begin
    known    = (req == fbssm_pkg::ST_INIT) || (req == fbssm_pkg::ST_PREOP) ||
               (req == fbssm_pkg::ST_BOOT) || (req == fbssm_pkg::ST_SAFEOP) ||
               (req == fbssm_pkg::ST_OP);
    // Bootstrap only leaves towards Init; anything else would skip mailbox setup
    bad_pair = ((cur == fbssm_pkg::ST_INIT) && (req == fbssm_pkg::ST_SAFEOP)) ||
               ((cur == fbssm_pkg::ST_INIT) && (req == fbssm_pkg::ST_OP)) ||
               ((cur == fbssm_pkg::ST_PREOP) && (req == fbssm_pkg::ST_OP)) ||
               ((cur != fbssm_pkg::ST_INIT) && (cur != fbssm_pkg::ST_BOOT) &&
                (req == fbssm_pkg::ST_BOOT)) ||
               ((cur == fbssm_pkg::ST_BOOT) && (req != fbssm_pkg::ST_INIT) &&
                (req != fbssm_pkg::ST_BOOT));
    in_run   = (cur == fbssm_pkg::ST_OP) || (cur == fbssm_pkg::ST_SAFEOP);
  end

  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    err_set    = 1'b0;
    if (ctrl_wr) begin
      err_set = 1'b1;
      if (!known) begin
        code_next = fbssm_pkg::CODE_UNKNWN;
      end else if (bad_pair) begin
        code_next = fbssm_pkg::CODE_BADCHG;
      end else if ((cur == fbssm_pkg::ST_INIT) && (req == fbssm_pkg::ST_BOOT) &&
                   fault_in.mbx_boot_bad) begin
        code_next = fbssm_pkg::CODE_MBXBT;
      end else if ((cur == fbssm_pkg::ST_INIT) && (req == fbssm_pkg::ST_PREOP) &&
                   fault_in.mbx_preop_bad) begin
        code_next = fbssm_pkg::CODE_MBXPO;
      end else if ((((cur == fbssm_pkg::ST_PREOP) && (req == fbssm_pkg::ST_SAFEOP)) ||
                    ((cur == fbssm_pkg::ST_SAFEOP) && (req == fbssm_pkg::ST_OP))) &&
                   fault_in.sm_cfg_bad) begin
        code_next = fbssm_pkg::CODE_SMCFG;
      end else if ((cur == fbssm_pkg::ST_PREOP) && (req == fbssm_pkg::ST_SAFEOP) &&
                   fault_in.out_cfg_bad) begin
        code_next = fbssm_pkg::CODE_OUTCFG;
      end else if ((cur == fbssm_pkg::ST_PREOP) && (req == fbssm_pkg::ST_SAFEOP) &&
                   fault_in.in_cfg_bad) begin
        code_next = fbssm_pkg::CODE_INCFG;
      end else begin
        err_set    = 1'b0;
        state_next = dec(req);
        code_next  = fbssm_pkg::CODE_NONE;
      end
    end
    // Run-time faults override a request in the same cycle: safety first
    if (in_run && fault_in.sm_wdog_exp) begin
      state_next = fbssm_pkg::FBSSM_SAFEOP;
      code_next  = fbssm_pkg::CODE_WDOG;
      err_set    = 1'b1;
    end else if (in_run && fault_in.out_cfg_bad) begin
      state_next = fbssm_pkg::FBSSM_SAFEOP;
      code_next  = fbssm_pkg::CODE_OUTCFG;
      err_set    = 1'b1;
    end else if (in_run && fault_in.in_cfg_bad) begin
      state_next = fbssm_pkg::FBSSM_PREOP;
      code_next  = fbssm_pkg::CODE_INCFG;
      err_set    = 1'b1;
    end else if (fault_in.unspec_err) begin
      state_next = state_reg;
      code_next  = fbssm_pkg::CODE_UNSPEC;
      err_set    = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= fbssm_pkg::FBSSM_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Status code register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_reg <= fbssm_pkg::CODE_RST;
    end else begin
      code_reg <= code_next;
    end
  end

  // ==========================================================
  // Change flag: a new error beats an acknowledge in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_reg <= 1'b0;
    end else if (err_set) begin
      flag_reg <= 1'b1;
    end else if (ctrl_wr && bus_in.wdata[fbssm_pkg::ACK_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Control register store and read port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= fbssm_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= bus_in.wdata[4:0] & fbssm_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_reg <= fbssm_pkg::RDATA_RST;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        fbssm_pkg::CTRL_ADDR: rd_data_reg <= {11'h000, ctrl_reg};
        fbssm_pkg::STAT_ADDR: rd_data_reg <= {11'h000, flag_reg, cur};
        fbssm_pkg::CODE_ADDR: rd_data_reg <= code_reg;
        default:              rd_data_reg <= 16'h0000;
      endcase
    end
  end

  assign rd_data_out = rd_data_reg;
  assign state_out   = cur;
  assign flag_out    = flag_reg;
  assign code_out    = code_reg;

  // ==========================================================
  // Checks
  reset_init_a: assert property (@(posedge clk_in) $rose(rst_b_in) |->
    (state_out == fbssm_pkg::ST_INIT) && !flag_out && (code_out == 16'h0000))
    else $error("not Init after reset");

  unknown_req_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && !known && !in_run && !fault_in.unspec_err |=>
    (code_out == 16'h0012) && flag_out && $stable(state_out))
    else $error("unknown request not refused");

  bad_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && known && bad_pair && !in_run && !fault_in.unspec_err |=>
    (code_out == 16'h0011) && flag_out && $stable(state_out))
    else $error("illegal transition accepted");

  mbx_boot_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && (cur == 4'h1) && (req == 4'h3) && fault_in.mbx_boot_bad &&
    !fault_in.unspec_err |=> (state_out == 4'h1) && (code_out == 16'h0015) && flag_out)
    else $error("bootstrap mailbox fault missed");

  mbx_preop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && (cur == 4'h1) && (req == 4'h2) && fault_in.mbx_preop_bad &&
    !fault_in.unspec_err |=> (state_out == 4'h1) && (code_out == 16'h0016) && flag_out)
    else $error("preop mailbox fault missed");

  wdog_drop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_run && fault_in.sm_wdog_exp |=>
    (state_out == 4'h4) && (code_out == 16'h001b) && flag_out)
    else $error("watchdog did not drop to SafeOp");

  ack_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && bus_in.wdata[4] && !err_set |=> !flag_out)
    else $error("acknowledge did not clear flag");

  good_move_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctrl_wr && !err_set |=> (state_out == $past(req)) && (code_out == 16'h0000)
    ##1 (state_out == $past(req, 2)) || $changed(state_out) || $changed(code_out))
    else $error("accepted request not taken");

  status_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    bus_in.rd && (bus_in.addr == 16'h0130) |=>
    (rd_data_out == {11'h000, $past(flag_reg), $past(cur)}))
    else $error("status readback wrong");
endmodule : fbssm_top
`default_nettype wire

// ### tb/fbssm_master_model.sv
// Purpose: Master side of the register port, issuing state requests
// Assumes: Accesses launched 1 ns after the rising edge, one edge each
// Notes:   Idle bus shows inverted last address and data, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module fbssm_master_model (
  // Clock
  input  wire logic                  clk_in,
  // Register port
  output var  fbssm_pkg::fbssm_bus_s bus_out,
  input  wire logic [15:0]           rd_data_in
);
  initial bus_out = '0;
  // ==========================================================
  // Single access, then release
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1 bus_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    #1 bus_out = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask : access
  // Extra edge so the answer has settled with up to two cycles of latency
  task automatic read_reg(input logic [15:0] a, output logic [15:0] q);
    access(1'h0, a, 16'h0000);
    @(posedge clk_in);
    #1 q = rd_data_in;
  endtask : read_reg
endmodule : fbssm_master_model
`default_nettype wire

// ### tb/fbssm_tb_top.sv
// Purpose: Self-checking bench for the slave state machine
// Assumes: Master model drives the register port, bench drives faults
// Notes:   Each step is a request or a fault pulse, then a status and code readback
`timescale 1ns/1ps
`default_nettype none
module fbssm_tb_top;
  typedef struct packed {
    logic pulse; logic [6:0] f; logic [15:0] d; logic [3:0] s; logic fl; logic [15:0] c;
  } fbssm_step_s;
  logic                    clk_in   = 1'h0;
  logic                    rst_b_in = 1'h0;
  fbssm_pkg::fbssm_bus_s   bus;
  logic [6:0]              fault    = 7'h00;
  logic [15:0]             rd_data;
  logic [15:0]             code;
  logic [3:0]              state;
  logic                    flag;
  logic [15:0]             q;
  int                      n_errors = 0;
  int                      checked  = 0;
  // Fault bits: 40 unspec, 20/10 mailbox, 08 sync cfg, 04 watchdog, 02 out, 01 in
  fbssm_step_s steps [33] = '{
    '{1'h0,7'h00,16'h0004,4'h1,1'h1,16'h0011}, '{1'h0,7'h00,16'h0001,4'h1,1'h1,16'h0000},
    '{1'h0,7'h00,16'h0008,4'h1,1'h1,16'h0011}, '{1'h0,7'h00,16'h0005,4'h1,1'h1,16'h0012},
    '{1'h0,7'h00,16'h0000,4'h1,1'h1,16'h0012}, '{1'h0,7'h00,16'h0011,4'h1,1'h0,16'h0000},
    '{1'h0,7'h20,16'h0003,4'h1,1'h1,16'h0015}, '{1'h0,7'h10,16'h0002,4'h1,1'h1,16'h0016},
    '{1'h0,7'h00,16'h0012,4'h2,1'h0,16'h0000}, '{1'h0,7'h00,16'h0008,4'h2,1'h1,16'h0011},
    '{1'h0,7'h00,16'h0003,4'h2,1'h1,16'h0011}, '{1'h0,7'h08,16'h0004,4'h2,1'h1,16'h0017},
    '{1'h0,7'h02,16'h0004,4'h2,1'h1,16'h001d}, '{1'h0,7'h01,16'h0004,4'h2,1'h1,16'h001e},
    '{1'h0,7'h00,16'h0014,4'h4,1'h0,16'h0000}, '{1'h0,7'h00,16'h0003,4'h4,1'h1,16'h0011},
    '{1'h0,7'h08,16'h0008,4'h4,1'h1,16'h0017}, '{1'h0,7'h00,16'h0018,4'h8,1'h0,16'h0000},
    '{1'h0,7'h00,16'h0003,4'h8,1'h1,16'h0011}, '{1'h0,7'h00,16'h0018,4'h8,1'h0,16'h0000},
    '{1'h1,7'h04,16'h0000,4'h4,1'h1,16'h001b}, '{1'h0,7'h00,16'h0018,4'h8,1'h0,16'h0000},
    '{1'h1,7'h02,16'h0000,4'h4,1'h1,16'h001d}, '{1'h0,7'h00,16'h0018,4'h8,1'h0,16'h0000},
    '{1'h1,7'h01,16'h0000,4'h2,1'h1,16'h001e}, '{1'h1,7'h40,16'h0000,4'h2,1'h1,16'h0001},
    '{1'h0,7'h00,16'h0011,4'h1,1'h0,16'h0000}, '{1'h0,7'h00,16'h0013,4'h3,1'h0,16'h0000},
    '{1'h0,7'h00,16'h0008,4'h3,1'h1,16'h0011}, '{1'h0,7'h00,16'h0011,4'h1,1'h0,16'h0000},
    '{1'h0,7'h00,16'h0012,4'h2,1'h0,16'h0000}, '{1'h0,7'h00,16'h0014,4'h4,1'h0,16'h0000},
    '{1'h1,7'h04,16'h0000,4'h4,1'h1,16'h001b}};

  always #5 clk_in = ~clk_in;

  fbssm_top DUT (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .bus_in      (bus),
    .rd_data_out (rd_data),
    .fault_in    (fault),
    .state_out   (state),
    .flag_out    (flag),
    .code_out    (code)
  );
  fbssm_master_model m (
    .clk_in     (clk_in),
    .bus_out    (bus),
    .rd_data_in (rd_data)
  );
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic expect_st(input logic [3:0] s, input logic f, input logic [15:0] c);
    logic [15:0] r;
    m.read_reg(fbssm_pkg::STAT_ADDR, r);
    chk(r, {11'h000, f, s}, "status register");
    chk({11'h000, flag, state}, {11'h000, f, s}, "status ports");
    m.read_reg(fbssm_pkg::CODE_ADDR, r);
    chk(r, c, "code register");
    chk(code, c, "code port");
  endtask : expect_st
  // ==========================================================
  // Stimulus
  // Fault held across the write so the request sees it
  task automatic req(input logic [6:0] f, input logic [15:0] d);
    fault = f;
    m.access(1'h1, fbssm_pkg::CTRL_ADDR, d);
    fault = 7'h00;
  endtask : req
  task automatic pulse(input logic [6:0] f);
    @(posedge clk_in);
    #1 fault = f;
    @(posedge clk_in);
    #1 fault = 7'h00;
  endtask : pulse
  initial begin
    repeat (10) @(posedge clk_in);
    #1 rst_b_in = 1'h1;
    expect_st(4'h1, 1'h0, 16'h0000);
    m.read_reg(fbssm_pkg::CTRL_ADDR, q);
    chk(q, 16'h0001, "control reset");
    m.read_reg(16'h0200, q);
    chk(q, 16'h0000, "unmapped read");
    m.access(1'h1, fbssm_pkg::STAT_ADDR, 16'h0008);
    expect_st(4'h1, 1'h0, 16'h0000);
    foreach (steps[i]) begin
      if (steps[i].pulse) begin
        pulse(steps[i].f);
      end else begin
        req(steps[i].f, steps[i].d);
      end
      expect_st(steps[i].s, steps[i].fl, steps[i].c);
    end
    // Reset in mid-run must return to the start state
    #3 rst_b_in = 1'h0;
    repeat (2) @(posedge clk_in);
    #1 rst_b_in = 1'h1;
    expect_st(4'h1, 1'h0, 16'h0000);
    conclude();
  end
  // Run needs well under 1000 cycles; generous margin
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    conclude();
  end
endmodule : fbssm_tb_top
`default_nettype wire
